//--- inc/stp_pkg.sv
// Shared constants, register map, state encodings and state record of the stepper translator and PWM core.
// Assumes a 200 MHz system clock and one APB slave port with 32-bit data.
package stp_pkg;

    // =====================================================================
    // Timing
    // =====================================================================
    localparam int CLK_PS        = 5000;
    localparam int PWM_PERIOD_NS = 50000;
    localparam int PWM_CYC       = (PWM_PERIOD_NS * 1000) / CLK_PS;
    localparam int DEAD_NS       = 100;
    localparam int DEAD_CYC      = (DEAD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int TRANS_NS      = 300;
    localparam int TRANS_CYC     = (TRANS_NS * 1000) / CLK_PS;
    localparam int PWM_CW        = 16;
    localparam int DEAD_CW       = 6;
    localparam int TRANS_CW      = 7;
    localparam logic [DEAD_CW-1:0]  DEAD_LD   = DEAD_CW'(DEAD_CYC);
    localparam logic [TRANS_CW-1:0] TRANS_LIM = TRANS_CW'(TRANS_CYC);

    // =====================================================================
    // Register map and fields
    // =====================================================================
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_POS  = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_SETP = 8'h0C;
    localparam int CTRL_EN    = 0;
    localparam int CTRL_DIRECTION_POLARITY_BIT  = 1;
    localparam int CTRL_STEP  = 2;
    localparam int CTRL_BRAKE = 3;
    localparam int CTRL_RES   = 4;
    localparam int STAT_FLT   = 8;
    localparam logic [2:0] RES_16   = 3'h0;
    localparam logic [2:0] RES_FULL = 3'h4;
    localparam logic [2:0] RES_RST  = RES_16;
    localparam logic [5:0] POS_RST  = 6'h08;

    // =====================================================================
    // Encodings and state record
    // =====================================================================
    typedef enum logic [4:0] {
        DR_OFF   = 5'b00001,
        DR_FWD   = 5'b00010,
        DR_SLOW  = 5'b00100,
        DR_FAST  = 5'b01000,
        DR_BRAKE = 5'b10000
    } stp_drive_t;

    typedef enum logic [2:0] {
        HB_OFF = 3'b001,
        HB_HI  = 3'b010,
        HB_LO  = 3'b100
    } stp_half_t;

    typedef struct packed {
        logic                          en;
        logic                          direction_polarity_bit;
        logic                          brake;
        logic [2:0]                    res;
        logic [5:0]                    pos;
        logic                          sw_step;
        logic                          step_prev;
        logic [31:0]                   prdata;
        logic [PWM_CW-1:0]             pwm_cnt;
        stp_drive_t [1:0]              drive;
        logic [1:0]                    top;
        logic [1:0]                    reached;
        logic [1:0]                    fast;
        logic [1:0][7:0]               prev_mag;
        logic [1:0]                    prev_neg;
        stp_half_t [3:0]               half;
        logic [3:0][DEAD_CW-1:0]       dead;
        logic [7:0][TRANS_CW-1:0]      on_cnt;
        logic [7:0]                    flt;
        logic [7:0]                    gate;
    } stp_state_t;

    // Quarter-wave sine, full scale 8'hFF, index 0 to 16 over 90 degrees.
    function automatic logic [7:0] stp_quarter(input logic [4:0] k);
        case (k)
            5'h00: stp_quarter = 8'h00;
            5'h01: stp_quarter = 8'h19;
            5'h02: stp_quarter = 8'h32;
            5'h03: stp_quarter = 8'h4A;
            5'h04: stp_quarter = 8'h62;
            5'h05: stp_quarter = 8'h78;
            5'h06: stp_quarter = 8'h8E;
            5'h07: stp_quarter = 8'hA2;
            5'h08: stp_quarter = 8'hB4;
            5'h09: stp_quarter = 8'hC5;
            5'h0A: stp_quarter = 8'hD4;
            5'h0B: stp_quarter = 8'hE1;
            5'h0C: stp_quarter = 8'hEC;
            5'h0D: stp_quarter = 8'hF4;
            5'h0E: stp_quarter = 8'hFA;
            5'h0F: stp_quarter = 8'hFE;
            default: stp_quarter = 8'hFF;
        endcase
    endfunction

    // Magnitude of sin(2*pi*p/64); the sign is p[5].
    function automatic logic [7:0] stp_sin_mag(input logic [5:0] p);
        stp_sin_mag = stp_quarter(p[4] ? (5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]});
    endfunction

endpackage

//--- hdl/stp_core.sv
// Stepper translator and dual-bridge PWM current regulation core with an APB register slave.
// Assumes the analog front end supplies per-bridge current comparators and per-switch overvoltage flags,
// and that all inputs are synchronous to clk.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps

module stp_core
    import stp_pkg::*;
#(
    parameter int PWM_CYC_P = PWM_CYC
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        step_pulse_pin,
    input  wire logic        dir_pin,
    input  wire logic [1:0]  cur_reached,
    input  wire logic [7:0]  vds_high,
    output logic      [7:0]  gate,
    output logic      [7:0]  set_x_mag,
    output logic             set_x_neg,
    output logic      [7:0]  set_y_mag,
    output logic             set_y_neg
);

    // =====================================================================
    // Derived PWM instants
    // =====================================================================
    localparam logic [PWM_CW-1:0] CNT_LAST = PWM_CW'(PWM_CYC_P - 1);
    localparam logic [PWM_CW-1:0] HALF     = PWM_CW'(PWM_CYC_P / 2);
    localparam logic [PWM_CW-1:0] Q3       = PWM_CW'((PWM_CYC_P * 3) / 4);
    localparam int                BRK_WAIT = DEAD_CYC + 3;

    stp_state_t s;
    stp_state_t n;
    logic       pin_rise;
    logic       eff_dir;
    logic       acc;
    logic       wr;
    logic       mapped;
    logic       pos_wr;
    logic       act;
    logic [1:0][7:0] mag;
    logic [1:0]      neg;
    logic [5:0]      cos_p;
    logic [5:0]      step_sz;
    logic [1:0]      ntrig;

    // One move of the translator: an off-grid position first snaps to the coarse grid.
    function automatic logic [5:0] step_once(input logic [5:0] p, input logic [5:0] sz, input logic up);
        logic [5:0] m;
        m = sz - 6'h01;
        if ((p & m) != 6'h00) begin
            step_once = up ? ((p & ~m) + sz) : (p & ~m);
        end else begin
            step_once = up ? (p + sz) : (p - sz);
        end
    endfunction

    // =====================================================================
    // Combinational helpers
    // =====================================================================
    // Set points come straight from the live position so position writes reach the coils at once.
    assign pin_rise  = step_pulse_pin & ~s.step_prev;
    assign eff_dir   = dir_pin ^ s.direction_polarity_bit;
    assign acc       = psel & penable;
    assign wr        = acc & pwrite;
    assign mapped    = (paddr == ADDR_CTRL) || (paddr == ADDR_POS) || (paddr == ADDR_STAT) || (paddr == ADDR_SETP);
    assign pos_wr    = wr & pstrb[0] & (paddr == ADDR_POS);
    assign cos_p     = s.pos + 6'h10;
    assign mag[0]    = stp_sin_mag(cos_p);
    assign neg[0]    = cos_p[5];
    assign mag[1]    = stp_sin_mag(s.pos);
    assign neg[1]    = s.pos[5];
    assign act       = mag[1] > mag[0];
    assign step_sz   = 6'h01 << s.res;
    assign ntrig     = {1'b0, pin_rise} + {1'b0, s.sw_step};

    // =====================================================================
    // Next-state logic
    // =====================================================================
    // All state is updated here; later assignments take priority over earlier ones.
    always_comb begin
        stp_drive_t dsel;
        stp_half_t  want_a;
        stp_half_t  want_b;
        logic       rch;
        logic       tp;
        dsel   = DR_OFF;
        want_a = HB_OFF;
        want_b = HB_OFF;
        rch    = 1'b0;
        tp     = 1'b0;
        n      = s;
        n.step_prev = step_pulse_pin;

        // Translator moves with whatever resolution is current at the trigger.
        if (!s.brake) begin
            for (int k = 0; k < 2; k++) begin
                if (k < int'(ntrig)) begin
                    n.pos = step_once(n.pos, step_sz, eff_dir);
                end
            end
        end
        n.sw_step = 1'b0;

        // PWM period counter stands at zero while the drivers are off.
        if (!s.en) begin
            n.pwm_cnt = '0;
        end else if (s.pwm_cnt == CNT_LAST) begin
            n.pwm_cnt = '0;
        end else begin
            n.pwm_cnt = s.pwm_cnt + PWM_CW'(1);
        end

        // Per-bridge regulation loop.
        for (int b = 0; b < 2; b++) begin
            dsel = s.drive[b];
            rch  = s.reached[b];
            tp   = s.top[b];
            if (!s.en) begin
                dsel = DR_OFF;
                rch  = 1'b0;
                tp   = 1'b0;
            end else if (s.brake) begin
                dsel = (int'(act) == b) ? DR_BRAKE : DR_OFF;
            end else if (s.pwm_cnt == '0) begin
                // A drop or sign change of the set point picks fast decay for this period.
                n.fast[b]     = (mag[b] < s.prev_mag[b]) || (neg[b] != s.prev_neg[b]);
                n.prev_mag[b] = mag[b];
                n.prev_neg[b] = neg[b];
                rch  = 1'b0;
                dsel = DR_FWD;
            end else if (s.drive[b] == DR_FWD) begin
                if (cur_reached[b] && !s.reached[b]) begin
                    rch = 1'b1;
                    if (s.pwm_cnt < HALF) begin
                        tp = 1'b0;
                    end
                end
                if (s.pwm_cnt == Q3 && !rch) begin
                    tp = 1'b1;
                end
                // Reaching the current ends forward drive at any point; a reach before half of the period clears top regulation.
                if (rch && (!tp || s.pwm_cnt >= HALF)) begin
                    dsel = s.fast[b] ? DR_FAST : DR_SLOW;
                end
            end
            n.drive[b]   = dsel;
            n.reached[b] = rch;
            n.top[b]     = tp;

            // Half-bridge targets from the drive mode and current sign.
            case (dsel)
                DR_FWD: begin
                    want_a = neg[b] ? HB_LO : HB_HI;
                    want_b = neg[b] ? HB_HI : HB_LO;
                end
                DR_FAST: begin
                    want_a = neg[b] ? HB_HI : HB_LO;
                    want_b = neg[b] ? HB_LO : HB_HI;
                end
                DR_SLOW, DR_BRAKE: begin
                    want_a = HB_LO;
                    want_b = HB_LO;
                end
                default: begin
                    want_a = HB_OFF;
                    want_b = HB_OFF;
                end
            endcase
            for (int h = 2 * b; h < 2 * b + 2; h++) begin
                stp_half_t w;
                w = (h == 2 * b) ? want_a : want_b;
                if (w == s.half[h]) begin
                    n.dead[h] = (s.dead[h] != '0) ? s.dead[h] - DEAD_CW'(1) : '0;
                end else if (s.half[h] != HB_OFF) begin
                    n.half[h] = HB_OFF;
                    n.dead[h] = DEAD_LD;
                end else if (s.dead[h] == '0 || w == HB_OFF) begin
                    n.half[h] = w;
                end else begin
                    n.dead[h] = s.dead[h] - DEAD_CW'(1);
                end
            end
        end

        // Short protection: a switch on past its transition time with high drop is latched off.
        for (int j = 0; j < 8; j++) begin
            n.on_cnt[j] = !s.gate[j] ? '0 :
                          (s.on_cnt[j] == TRANS_LIM) ? s.on_cnt[j] : s.on_cnt[j] + TRANS_CW'(1);
            if (wr && pstrb[1] && paddr == ADDR_STAT && pwdata[STAT_FLT + j]) begin
                n.flt[j] = 1'b0;
            end
            if (s.gate[j] && vds_high[j] && s.on_cnt[j] >= TRANS_LIM) begin
                n.flt[j] = 1'b1;
            end
        end
        for (int h = 0; h < 4; h++) begin
            n.gate[2*h]   = n.en && n.half[h] == HB_HI && !n.flt[2*h];
            n.gate[2*h+1] = n.en && n.half[h] == HB_LO && !n.flt[2*h+1];
        end

        // CTRL and POS writes land last so software wins over self-clearing.
        if (wr && pstrb[0] && paddr == ADDR_CTRL) begin
            n.en      = pwdata[CTRL_EN];
            // Clearing enable drops the gates and the period counter in the same edge as the bit itself.
            if (!pwdata[CTRL_EN]) begin
                n.pwm_cnt = '0;
                n.gate    = '0;
            end
            n.direction_polarity_bit    = pwdata[CTRL_DIRECTION_POLARITY_BIT];
            n.sw_step = pwdata[CTRL_STEP];
            n.brake   = pwdata[CTRL_BRAKE];
            if (pwdata[CTRL_RES+2:CTRL_RES] <= RES_FULL) begin
                n.res = pwdata[CTRL_RES+2:CTRL_RES];
            end
        end
        if (pos_wr) begin
            n.pos = pwdata[5:0];
        end

        // Read data is captured in the setup phase and shown in the access phase.
        if (psel && !penable) begin
            if (paddr == ADDR_CTRL) begin
                n.prdata = {25'h0000000, s.res, s.brake, s.sw_step, s.direction_polarity_bit, s.en};
            end else if (paddr == ADDR_POS) begin
                n.prdata = {26'h0000000, s.pos};
            end else if (paddr == ADDR_STAT) begin
                n.prdata = {16'h0000, s.flt, 2'h0, dir_pin, eff_dir, s.reached, s.top};
            end else if (paddr == ADDR_SETP) begin
                n.prdata = {7'h00, neg[1], mag[1], 7'h00, neg[0], mag[0]};
            end else begin
                n.prdata = 32'h00000000;
            end
        end
    end

    // =====================================================================
    // State register
    // =====================================================================
    // Synchronous reset to defaults; the drivers come up off.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s          <= '0;
            s.res      <= RES_RST;
            s.pos      <= POS_RST;
            s.drive    <= {DR_OFF, DR_OFF};
            s.half     <= {HB_OFF, HB_OFF, HB_OFF, HB_OFF};
        end else begin
            s <= n;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    assign prdata    = s.prdata;
    assign pready    = acc;
    assign pslverr   = acc & ~mapped;
    assign gate      = s.gate;
    assign set_x_mag = mag[0];
    assign set_x_neg = neg[0];
    assign set_y_mag = mag[1];
    assign set_y_neg = neg[1];

    // =====================================================================
    // Checks
    // =====================================================================
    no_shoot_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s.gate & (s.gate >> 1) & 8'h55) == 8'h00)
        else $error("upper and lower switch of one half-bridge on together");

    dead_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(s.gate[0]) |-> !s.gate[1] [*2])
        else $error("lower switch followed upper switch without dead time");

    off_hiz_a: assert property (@(posedge clk) disable iff (sys_rst)
        !s.en |-> (s.gate == 8'h00 && s.pwm_cnt == '0))
        else $error("bridge driven while drivers disabled");

    step_one_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s.res == RES_16 && pin_rise && !s.sw_step && !s.brake && !pos_wr)
        |=> s.pos == ($past(eff_dir) ? $past(s.pos) + 6'h01 : $past(s.pos) - 6'h01))
        else $error("sixteenth step did not move position by one");

    full_grid_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s.res == RES_FULL && ntrig != 2'h0 && !s.brake && !pos_wr) |=> s.pos[3:0] == 4'h0)
        else $error("full step left the position off the full-step grid");

    brake_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s.brake && !pos_wr) |=> $stable(s.pos))
        else $error("position moved during active brake");

    top_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s.en && !s.brake && s.drive[0] == DR_FWD && s.pwm_cnt == Q3 && !s.reached[0] && !cur_reached[0])
        |=> s.top[0])
        else $error("top regulation not entered at three quarters of period");

    brake_low_a: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(s.brake) && s.en && s.flt == 8'h00 && !act) ##1 (s.brake && s.en && s.flt == 8'h00) [*2]
        |-> ##[0:BRK_WAIT] (s.gate[1] && s.gate[3]))
        else $error("brake did not close both lower switches of the active bridge");

    pos_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        pos_wr |=> s.pos == $past(pwdata[5:0]))
        else $error("position write not applied at once");

endmodule

//--- dv/stp_mcu_model.sv
// Model of the microcontroller side: step pulses on the pin and a steady direction pin.
// Assumes go is a one-cycle request from the bench, synchronous to clk.
`timescale 1ns/1ps

module stp_mcu_model (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic go,
    input  wire logic dir_req,
    output logic      step_pulse_pin,
    output logic      dir_pin
);
    // =====================================================================
    // Pulse generator
    // =====================================================================
    logic [3:0] cnt;

    // Direction only follows the request while idle, so it never moves around a step edge.
    always @(posedge clk) begin
        if (sys_rst) begin
            cnt <= 4'h0;
            dir_pin <= 1'b0;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else begin
            dir_pin <= dir_req;
            if (go) begin
                cnt <= 4'hF;
            end
        end
    end

    // High for eight cycles, then low for seven: one rising edge per request.
    assign step_pulse_pin = cnt[3];
endmodule

//--- dv/stp_core_tb.sv
// Self-checking bench of the stepper core: APB accesses, pin steps, brake, PWM and fault checks.
// Assumes a zero-wait APB slave and a shortened PWM period of 200 cycles.
`timescale 1ns/1ps

module stp_core_tb;
    import stp_pkg::*;
    logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        go = 1'b0, dir_req = 1'b0, pready, pslverr, step_pulse_pin, dir_pin, last_err, dp;
    logic        set_x_neg, set_y_neg;
    logic [7:0]  paddr = 8'h00, vds_high = 8'h00, gate, set_x_mag, set_y_mag;
    logic [31:0] pwdata = 32'h0, prdata, q, p1;
    logic [3:0]  pstrb = 4'h0;
    logic [1:0]  cur_reached = 2'h0;
    int          err_count = 0, total_checks = 0, n;

    // =====================================================================
    // Clock, design and partner
    // =====================================================================
    always #2.5 clk = ~clk;
    stp_core #(.PWM_CYC_P(200)) i_stp_core (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .step_pulse_pin, .dir_pin, .cur_reached, .vds_high, .gate,
        .set_x_mag, .set_x_neg, .set_y_mag, .set_y_neg);
    stp_mcu_model i_stp_mcu_model (.clk, .sys_rst, .go, .dir_req, .step_pulse_pin, .dir_pin);

    // =====================================================================
    // Tasks
    // =====================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One APB transfer; the request is held until pready is seen high at a rising edge.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) begin
            chk(32'h0, 32'h1);
            results();
        end
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    task automatic waitg(input logic [7:0] e);
        n = 0;
        while (gate !== e && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk({24'h0, gate}, {24'h0, e});
        if (n >= 2000) begin
            results();
        end
    endtask

    // Direction is settled two cycles before the pulse is requested.
    task automatic mstep(input logic d);
        dir_req <= d;
        repeat (2) @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (20) @(posedge clk);
    endtask

    function automatic logic [31:0] ctl(input logic e, d, s, b, input logic [2:0] r);
        return {25'h0, r, b, s, d, e};
    endfunction

    // Interlock watch: both switches of one half-bridge on together is never allowed.
    always @(posedge clk) begin
        if (!sys_rst && ((gate[0] & gate[1]) | (gate[2] & gate[3]) | (gate[4] & gate[5]) | (gate[6] & gate[7]))) begin
            chk(32'h1, 32'h0);
        end
    end

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rdc(ADDR_CTRL, 32'h0);
        rdc(ADDR_POS, 32'h8);
        rdc(ADDR_SETP, 32'h00B400B4);
        // The sense of "up" is learnt from the first step, then XOR of pin and polarity is checked.
        mstep(1'b0);
        xfer(1'b0, ADDR_POS, 32'h0);
        chk({31'h0, q === 32'h9 || q === 32'h7}, 32'h1);
        p1 = q;
        dp = (q !== 32'h9);
        xfer(1'b1, ADDR_CTRL, ctl(1'b0, 1'b1, 1'b0, 1'b0, RES_16));
        mstep(1'b0);
        rdc(ADDR_POS, 32'h8);
        mstep(1'b1);
        rdc(ADDR_POS, p1);
        dir_req <= 1'b0;
        xfer(1'b1, ADDR_POS, 32'h8);
        xfer(1'b1, ADDR_CTRL, ctl(1'b0, dp, 1'b1, 1'b0, RES_16));
        rdc(ADDR_POS, 32'h9);
        rdc(ADDR_CTRL, ctl(1'b0, dp, 1'b0, 1'b0, RES_16));
        $display("test direction done");
        for (int r = 1; r <= 4; r++) begin
            xfer(1'b1, ADDR_POS, 32'h0);
            xfer(1'b1, ADDR_CTRL, ctl(1'b0, dp, 1'b0, 1'b0, 3'(r)));
            rdc(ADDR_POS, 32'h0);
            xfer(1'b1, ADDR_CTRL, ctl(1'b0, dp, 1'b1, 1'b0, 3'(r)));
            rdc(ADDR_POS, 32'h1 << r);
        end
        xfer(1'b0, ADDR_SETP, 32'h0);
        chk(q & 32'h00FF00FF, 32'h00FF0000);
        xfer(1'b1, ADDR_POS, 32'h3F);
        xfer(1'b1, ADDR_CTRL, ctl(1'b0, dp, 1'b1, 1'b0, RES_16));
        rdc(ADDR_POS, 32'h0);
        rdc(ADDR_SETP, 32'h000000FF);
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, ADDR_POS, 32'h5);
            xfer(1'b1, ADDR_CTRL, ctl(1'b0, dp ^ i[0], 1'b1, 1'b0, 3'h2));
            rdc(ADDR_POS, i ? 32'h4 : 32'h8);
        end
        xfer(1'b1, ADDR_POS, 32'h10);
        xfer(1'b1, ADDR_CTRL, ctl(1'b0, dp, 1'b0, 1'b0, RES_FULL));
        xfer(1'b1, ADDR_CTRL, ctl(1'b0, dp, 1'b1, 1'b0, RES_16));
        rdc(ADDR_POS, 32'h11);
        xfer(1'b1, ADDR_CTRL, ctl(1'b0, dp, 1'b0, 1'b0, 3'h5));
        rdc(ADDR_CTRL, ctl(1'b0, dp, 1'b0, 1'b0, RES_16));
        xfer(1'b1, ADDR_CTRL, ctl(1'b0, dp, 1'b0, 1'b0, RES_FULL));
        xfer(1'b1, ADDR_POS, 32'h5);
        rdc(ADDR_POS, 32'h5);
        rdc(ADDR_SETP, 32'h007800E1);
        chk({7'h0, set_y_neg, set_y_mag, 7'h0, set_x_neg, set_x_mag}, 32'h007800E1);
        $display("test resolution done");
        xfer(1'b1, ADDR_POS, 32'h0);
        xfer(1'b1, ADDR_CTRL, ctl(1'b1, dp, 1'b0, 1'b1, RES_16));
        waitg(8'h0A);
        mstep(1'b0);
        rdc(ADDR_POS, 32'h0);
        xfer(1'b1, ADDR_CTRL, ctl(1'b0, dp, 1'b0, 1'b0, RES_16));
        waitg(8'h00);
        mstep(1'b0);
        rdc(ADDR_POS, 32'h1);
        $display("test brake and enable done");
        // With the comparators never tripping, both windings must fall into top regulation.
        xfer(1'b1, ADDR_CTRL, ctl(1'b1, dp, 1'b0, 1'b0, RES_16));
        n = 0;
        while (gate === 8'h00 && n < 500) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, gate !== 8'h00}, 32'h1);
        if (n >= 500) begin
            results();
        end
        repeat (450) @(posedge clk);
        xfer(1'b0, ADDR_STAT, 32'h0);
        chk(q & 32'h3, 32'h3);
        cur_reached <= 2'h3;
        repeat (450) @(posedge clk);
        xfer(1'b0, ADDR_STAT, 32'h0);
        chk(q & 32'h3, 32'h0);
        // A drop of the X set point reverses bridge X for one period, then slow decay returns.
        xfer(1'b1, ADDR_POS, 32'h8);
        waitg(8'hA6);
        waitg(8'hAA);
        $display("test pwm done");
        vds_high <= 8'hFF;
        repeat (450) @(posedge clk);
        xfer(1'b0, ADDR_STAT, 32'h0);
        chk({31'h0, q[15:8] != 8'h00}, 32'h1);
        vds_high <= 8'h00;
        xfer(1'b1, ADDR_STAT, 32'h0000FF00);
        xfer(1'b0, ADDR_STAT, 32'h0);
        chk(q & 32'hFF00, 32'h0);
        xfer(1'b0, 8'h10, 32'h0);
        chk({31'h0, last_err}, 32'h1);
        chk(q, 32'h0);
        $display("test fault and bus done");
        results();
    end
endmodule
